//--- ahi_regs.svh
// Pin positions, reset values and timing counts of the host interface
`ifndef AHI_REGS_SVH
`define AHI_REGS_SVH

////////////////////////////////////////////////////////////////////////
// Timing
`define AHI_CLK_PS      4000
`define AHI_CONV_NS     3000
`define AHI_CONV_CYC    ((`AHI_CONV_NS * 1000 + `AHI_CLK_PS - 1) / `AHI_CLK_PS)

////////////////////////////////////////////////////////////////////////
// Data path sizes
`define AHI_WORD_W      16
`define AHI_FIFO_DEPTH  32
`define AHI_CHANNELS    6

////////////////////////////////////////////////////////////////////////
// Shared pin positions on the data bus
`define AHI_PIN_SEL_A   0
`define AHI_PIN_SCLK    6
`define AHI_PIN_CHAIN   7
`define AHI_PIN_DOUT_A  8
`define AHI_PIN_WR_LO   8
`define AHI_PIN_WR_HI   15

////////////////////////////////////////////////////////////////////////
// Reset values
`define AHI_SYNC_RST    21'h0_0007
`define AHI_CTRL_RST    8'h00
`define AHI_REF_RST     1'h1

`endif

//--- ahi_pkg.sv
// Types shared by the host interface block
package ahi_pkg;

  typedef enum logic [1:0] {
    AHI_IDLE,
    AHI_CONV,
    AHI_PUSH
  } ahi_state_t;

  typedef struct packed {
    logic [20:0]       s1;
    logic [20:0]       s2;
    logic [20:0]       s3;
    logic [20:0]       flt;
    ahi_state_t        st;
    logic [15:0]       cnt;
    logic [2:0]        mask;
    logic [2:0]        ch;
    logic              push_v;
    logic [15:0]       push_d;
    logic              pop_req;
    logic              ser_load;
    logic [1:0]        lane;
    logic [2:0][15:0]  shift;
    logic [15:0]       pword;
    logic [15:0]       dbo;
    logic [15:0]       dboe;
    logic              busy;
    logic              ref_en;
    logic              chain_en;
    logic [7:0]        ctrl;
  } ahi_core_t;

endpackage : ahi_pkg

//--- ahi_fifo.sv
// Result FIFO between the converter side and the read side
`timescale 1ns/1ps

module ahi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // DEPTH must be a power of two; pointers wrap on their extra bit
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } ahi_fifo_st_t;

  ahi_fifo_st_t q;
  ahi_fifo_st_t next_q;
  logic [AW:0]  used;

  assign used      = q.wp - q.rp;
  assign in_ready  = (used != FULL);
  assign out_valid = (q.wp != q.rp);
  assign out_data  = q.mem[q.rp[AW-1:0]];

  always_comb begin
    next_q = q;
    if (in_valid && in_ready) begin
      next_q.mem[q.wp[AW-1:0]] = in_data;
      next_q.wp = q.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_q.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule : ahi_fifo

//--- ahi_pins.sv
// Host-facing pins of the six-channel converter: read, write, busy, serial
`timescale 1ns/1ps
`include "ahi_regs.svh"

// Overview of operation
// - Parallel read drives result on data bus
// - Parallel write captures upper byte into control
// - Serial frame select falling outputs result MSB
// - Write strobe writes control only when hardware-select high
// - Hardware-select low: write pin sets internal reference
// - Busy high from start until results latched
// - Mode pin: low parallel, high serial
// - Serial mode remaps outputs, lane selects, chain enable
// - Lane-select pins are three-state outputs in parallel
// - Lane A select enables lane A; hold high
// - Lane B select adds second serial lane
// - Lane C select adds third serial lane
// - Start rising edge puts pair into conversion
// - Bit eight carries serial data with lane A
module ahi_pins #(
  parameter int CONV_CYCLES = `AHI_CONV_CYC,
  parameter int FIFO_DEPTH  = `AHI_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        hw_sw_select,
  input  wire logic        serial_parallel_select,
  input  wire logic [2:0]  pair_conversion_start,
  input  wire logic [15:0] data_bus_bit_in,
  input  wire logic [95:0] chan_data,
  output logic [15:0]      data_bus_bit_out,
  output logic [15:0]      data_bus_bit_oe,
  output logic             busy,
  output logic             internal_ref_enable,
  output logic             chain_mode_enable,
  output logic [7:0]       ctrl_reg
);

  ////////////////////////////////////////////////////////////////////////
  // Positions inside the synchronised pin vector
  localparam int I_CS   = 0;
  localparam int I_RD   = 1;
  localparam int I_WR   = 2;
  localparam int I_SCLK = 3;
  localparam int I_SEL  = 4;
  localparam int I_CHN  = 7;
  localparam int I_CV   = 8;
  localparam int I_SER  = 11;
  localparam int I_HW   = 12;
  localparam int I_DH   = 13;
  localparam int DA     = `AHI_PIN_DOUT_A;
  localparam int WW     = `AHI_WORD_W;
  localparam logic [15:0] CNT_LOAD = 16'(CONV_CYCLES - 1);
  localparam logic [2:0]  CH_END   = 3'(`AHI_CHANNELS);

  ahi_pkg::ahi_core_t q;
  ahi_pkg::ahi_core_t next_q;

  logic [20:0] raw;
  logic [20:0] f;
  logic        rd_fall;
  logic        cs_fall;
  logic        sclk_fall;
  logic        wr_rise;
  logic [2:0]  cv_rise;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [15:0] fifo_out_data;

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling; a change counts once stages two and three agree
  assign raw = {data_bus_bit_in[`AHI_PIN_WR_HI:`AHI_PIN_WR_LO],
                hw_sw_select,
                serial_parallel_select,
                pair_conversion_start,
                data_bus_bit_in[`AHI_PIN_CHAIN],
                data_bus_bit_in[`AHI_PIN_SEL_A+2:`AHI_PIN_SEL_A],
                data_bus_bit_in[`AHI_PIN_SCLK],
                wr_n,
                rd_n,
                cs_n};

  assign f = (q.s3 & ~(q.s2 ^ q.s3)) | (q.flt & (q.s2 ^ q.s3));

  // Read strobe is ignored in serial mode, where the host parks it low
  assign rd_fall   = !f[I_SER] && (q.flt[I_CS] || q.flt[I_RD]) &&
                     !(f[I_CS] || f[I_RD]);
  assign cs_fall   = f[I_SER] && q.flt[I_CS] && !f[I_CS];
  assign sclk_fall = q.flt[I_SCLK] && !f[I_SCLK];
  assign wr_rise   = f[I_HW] && !f[I_SER] && !q.flt[I_CS] &&
                     !q.flt[I_WR] && f[I_WR];
  assign cv_rise   = f[I_CV+2:I_CV] & ~q.flt[I_CV+2:I_CV];

  ////////////////////////////////////////////////////////////////////////
  // Result FIFO; a full FIFO holds busy high until the reader drains it
  ahi_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (q.push_v),
    .in_ready  (fifo_in_ready),
    .in_data   (q.push_d),
    .out_valid (fifo_out_valid),
    .out_ready (q.pop_req),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;
    next_q.s1  = raw;
    next_q.s2  = q.s1;
    next_q.s3  = q.s2;
    next_q.flt = f;

    next_q.chain_en = f[I_SER] && f[I_CHN];
    if (!f[I_HW]) begin
      next_q.ref_en = f[I_WR];
    end
    // Upper byte sampled one cycle before the strobe rises
    if (wr_rise) begin
      next_q.ctrl = q.flt[I_DH+7:I_DH];
    end

    // Conversion sequence
    case (q.st)
      ahi_pkg::AHI_IDLE: begin
        // Edges while busy are dropped; the host must not send them
        if (|cv_rise) begin
          next_q.st   = ahi_pkg::AHI_CONV;
          next_q.mask = cv_rise;
          next_q.cnt  = CNT_LOAD;
          next_q.busy = 1'b1;
        end
      end
      ahi_pkg::AHI_CONV: begin
        if (q.cnt == 16'h0000) begin
          next_q.st = ahi_pkg::AHI_PUSH;
          next_q.ch = 3'h0;
        end else begin
          next_q.cnt = q.cnt - 16'h0001;
        end
      end
      ahi_pkg::AHI_PUSH: begin
        if (!q.push_v || fifo_in_ready) begin
          next_q.push_v = 1'b0;
          if (q.ch == CH_END) begin
            next_q.st   = ahi_pkg::AHI_IDLE;
            next_q.busy = 1'b0;
          end else begin
            next_q.push_v = q.mask[q.ch[2:1]];
            next_q.push_d = chan_data[q.ch*WW +: WW];
            next_q.ch     = q.ch + 3'h1;
          end
        end
      end
      default: begin
        next_q.st   = ahi_pkg::AHI_IDLE;
        next_q.busy = 1'b0;
      end
    endcase

    ////////////////////////////////////////////////////////////////////
    // Read side: one pop per parallel read, one per serial lane
    if (q.pop_req) begin
      if (q.ser_load) begin
        // Empty FIFO shifts out zeros rather than stale data
        next_q.shift[q.lane] = fifo_out_valid ? fifo_out_data : '0;
        if (q.lane == 2'h0 && f[I_SEL+1]) begin
          next_q.lane = 2'h1;
        end else if (q.lane != 2'h2 && f[I_SEL+2]) begin
          next_q.lane = 2'h2;
        end else begin
          next_q.ser_load = 1'b0;
        end
        next_q.pop_req = next_q.ser_load;
      end else begin
        if (fifo_out_valid) begin
          next_q.pword = fifo_out_data;
        end
        next_q.pop_req = 1'b0;
      end
    end
    if (rd_fall) begin
      next_q.pop_req  = 1'b1;
      next_q.ser_load = 1'b0;
    end
    if (cs_fall) begin
      next_q.pop_req  = 1'b1;
      next_q.ser_load = 1'b1;
      next_q.lane     = 2'h0;
      next_q.shift    = '0;
    end
    // Frame closed early: loading stops; the words for the remaining lanes stay in the FIFO
    if (f[I_SER] && f[I_CS] && q.ser_load) begin
      next_q.ser_load = 1'b0;
      next_q.pop_req  = 1'b0;
    end
    if (sclk_fall && f[I_SER] && !f[I_CS] && !q.flt[I_CS] &&
        !q.ser_load) begin
      for (int k = 0; k < 3; k++) begin
        next_q.shift[k] = {q.shift[k][14:0], 1'b0};
      end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drive
    if (f[I_SER]) begin
      next_q.dbo  = '0;
      next_q.dboe = '0;
      for (int k = 0; k < 3; k++) begin
        next_q.dbo[DA+k]  = next_q.shift[k][15];
        next_q.dboe[DA+k] = !f[I_CS] && f[I_SEL+k];
      end
    end else begin
      next_q.dbo  = next_q.pword;
      next_q.dboe = {16{!f[I_CS] && !f[I_RD]}};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.s1     <= `AHI_SYNC_RST;
      q.s2     <= `AHI_SYNC_RST;
      q.s3     <= `AHI_SYNC_RST;
      q.flt    <= `AHI_SYNC_RST;
      q.ctrl   <= `AHI_CTRL_RST;
      q.ref_en <= `AHI_REF_RST;
    end else begin
      q <= next_q;
    end
  end

  assign data_bus_bit_out    = q.dbo;
  assign data_bus_bit_oe     = q.dboe;
  assign busy                = q.busy;
  assign internal_ref_enable = q.ref_en;
  assign chain_mode_enable   = q.chain_en;
  assign ctrl_reg            = q.ctrl;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_PAR_OE: assert property (
    @(posedge clk) disable iff (rst)
    (!q.flt[I_SER] && !q.flt[I_CS] && !q.flt[I_RD])
      |-> data_bus_bit_oe == 16'hFFFF)
    else $error("Parallel read did not enable the bus");

  AST_CTRL_WR: assert property (
    @(posedge clk) disable iff (rst)
    (q.flt[I_HW] && !q.flt[I_SER] && !$past(q.flt[I_CS]) &&
     $rose(q.flt[I_WR]))
      |-> ctrl_reg == $past(q.flt[I_DH+7:I_DH]))
    else $error("Control byte not captured on write");

  AST_WR_IGNORED: assert property (
    @(posedge clk) disable iff (rst)
    !q.flt[I_HW] |-> $stable(ctrl_reg))
    else $error("Control changed with hardware select low");

  AST_REF_PIN: assert property (
    @(posedge clk) disable iff (rst)
    !q.flt[I_HW] |-> internal_ref_enable == q.flt[I_WR])
    else $error("Reference enable does not follow pin");

  AST_BUSY_RISE: assert property (
    @(posedge clk) disable iff (rst)
    (!$past(busy) && |(q.flt[I_CV+2:I_CV] & ~$past(q.flt[I_CV+2:I_CV])))
      |-> busy)
    else $error("Busy did not rise on conversion start");

  AST_BUSY_HOLD: assert property (
    @(posedge clk) disable iff (rst)
    $rose(busy) |-> busy [*8])
    else $error("Busy dropped during conversion");

  AST_BUSY_DROP: assert property (
    @(posedge clk) disable iff (rst)
    $fell(busy) |-> ($past(q.st) == ahi_pkg::AHI_PUSH && !q.push_v))
    else $error("Busy fell before results were latched");

  AST_SER_MSB: assert property (
    @(posedge clk) disable iff (rst)
    (q.flt[I_SER] && q.flt[I_SEL] && $fell(q.flt[I_CS]))
      |-> data_bus_bit_oe[DA] ##[1:4] !q.ser_load)
    else $error("Serial frame did not present lane A");

  AST_LANE_B: assert property (
    @(posedge clk) disable iff (rst)
    q.flt[I_SER]
      |-> data_bus_bit_oe[DA+1] == (!q.flt[I_CS] && q.flt[I_SEL+1]))
    else $error("Lane B enable wrong");

  AST_LANE_C: assert property (
    @(posedge clk) disable iff (rst)
    q.flt[I_SER]
      |-> data_bus_bit_oe[DA+2] == (!q.flt[I_CS] && q.flt[I_SEL+2]))
    else $error("Lane C enable wrong");

  AST_SHIFT: assert property (
    @(posedge clk) disable iff (rst)
    ($fell(q.flt[I_SCLK]) && q.flt[I_SER] && !q.flt[I_CS] &&
     !$past(q.flt[I_CS]) && !$past(q.ser_load))
      |-> data_bus_bit_out[DA] == $past(q.shift[0][14]))
    else $error("Serial lane A did not shift");

  AST_SER_PINS: assert property (
    @(posedge clk) disable iff (rst)
    q.flt[I_SER]
      |-> (data_bus_bit_oe[7:0] == 8'h00 && data_bus_bit_oe[15:11] == 5'h00))
    else $error("Non-lane pin driven in serial mode");

endmodule : ahi_pins

//--- ahi_host_model.sv
// Host processor model: frames one serial read and collects three lanes
`timescale 1ns/1ps

module ahi_host_model (
  input  wire logic       go,
  input  wire logic [2:0] dout,
  output logic            cs_n,
  output logic            sclk,
  output logic [47:0]     got,
  output logic            done
);
  // One process owns every output, so each has a single driver
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1; // Clock parks high outside frames
    got  = 48'h0000_0000_0000;
    done = 1'b1;
    forever begin
      @(posedge go);
      done = 1'b0;
      // Off the block's sampling edge, so no race on the pins
      #1;
      cs_n = 1'b0; // Frame opens, MSB comes out
      #400; // Covers pin sync plus lane loading
      for (int i = 15; i >= 0; i--) begin
        got[32 + i] = dout[0];
        got[16 + i] = dout[1];
        got[i]      = dout[2];
        if (i > 0) begin
          sclk = 1'b0; // Each fall moves the next bit out
          #80;
          sclk = 1'b1;
          #80;
        end
      end
      cs_n = 1'b1;
      done = 1'b1;
    end
  end
endmodule : ahi_host_model

//--- ahi_pins_tb.sv
// Bench for the host interface pins: parallel, write, reference, serial
`timescale 1ns/1ps

module ahi_pins_tb;
  typedef struct packed {
    logic [2:0] m;
    logic [7:0] c;
  } ahi_row_t;

  logic        clk, rst, cs_tb, rd_n, wr_n, hw, ser, chain, go;
  logic [2:0]  start, sel;
  logic [7:0]  hi, ctrl;
  logic [95:0] chan;
  logic [15:0] db_out, oe;
  logic        busy, ref_en, chain_en, host_cs, sclk, done;
  logic [47:0] got;
  int          bad_count, compares;
  ahi_row_t    rows [5];

  ahi_pins #(.CONV_CYCLES(10), .FIFO_DEPTH(32)) dut (
    .clk(clk), .rst(rst), .cs_n(ser ? host_cs : cs_tb), .rd_n(rd_n),
    .wr_n(wr_n), .hw_sw_select(hw), .serial_parallel_select(ser),
    .pair_conversion_start(start),
    .data_bus_bit_in({hi, chain, sclk & ser, 3'h0, sel}),
    .chan_data(chan), .data_bus_bit_out(db_out), .data_bus_bit_oe(oe),
    .busy(busy), .internal_ref_enable(ref_en),
    .chain_mode_enable(chain_en), .ctrl_reg(ctrl));

  // Undriven lanes read inverted, so a sample taken off-frame shows up
  ahi_host_model host (.go(go), .dout(db_out[10:8] ~^ oe[10:8]),
    .cs_n(host_cs), .sclk(sclk), .got(got), .done(done));

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] val(input int k);
    return {8'hC0 + 8'(k), 8'h5A};
  endfunction : val

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(48'(busy), 48'h1 - 48'h1);
  endtask : wait_idle

  task automatic rd_word(input logic [15:0] exp);
    cs_tb <= 1'b0;
    rd_n  <= 1'b0;
    cyc(10);
    chk(48'(oe), 48'h0000_0000_FFFF);
    chk(48'(db_out), 48'(exp));
    cs_tb <= 1'b1;
    rd_n  <= 1'b1;
    cyc(10);
  endtask : rd_word

  task automatic wr_ctrl(input logic [7:0] b);
    cs_tb <= 1'b0;
    hi    <= b;
    cyc(10);
    wr_n <= 1'b0;
    cyc(10);
    wr_n <= 1'b1;
    cyc(10);
    cs_tb <= 1'b1;
    cyc(10);
  endtask : wr_ctrl

  // Only after busy is low, as the host must
  task automatic conv(input logic [2:0] m, input bit to_idle);
    start <= m;
    cyc(8);
    chk(48'(busy), 48'h1);
    start <= 3'h0;
    if (to_idle) wait_idle();
  endtask : conv

  task automatic frame(input logic [2:0] s, input logic [15:0] eoe,
                       input logic [47:0] exp);
    logic [47:0] msk;
    int          n;
    msk = {{16{s[0]}}, {16{s[1]}}, {16{s[2]}}};
    sel <= s;
    cyc(10);
    go <= 1'b1;
    cyc(30);
    chk(48'(oe), 48'(eoe));
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk(48'(done), 48'h1);
    chk(got & msk, exp & msk);
    cyc(10);
    $display("serial frame %b done", s);
  endtask : frame

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {rst, cs_tb, rd_n, wr_n, hw} = 5'h1F;
    {ser, chain, go, start, sel, hi} = 17'h0;
    for (int k = 0; k < 6; k++) chan[16*k +: 16] = val(k);
    rows = '{'{3'b001, 8'hA5}, '{3'b010, 8'h5A}, '{3'b100, 8'hFF},
             '{3'b101, 8'h01}, '{3'b111, 8'h80}};
    cyc(12);
    rst <= 1'b0;
    cyc(8);
    foreach (rows[i]) begin
      wr_ctrl(rows[i].c);
      chk(48'(ctrl), 48'(rows[i].c));
      conv(rows[i].m, 1'b1);
      for (int p = 0; p < 3; p++) begin
        if (rows[i].m[p]) begin
          rd_word(val(2 * p));
          rd_word(val(2 * p + 1));
        end
      end
      $display("row %0d done", i);
    end
    // Shared write pin steers the reference while hardware-select is low
    hw   <= 1'b0;
    wr_n <= 1'b0;
    cyc(10);
    chk(48'(ref_en), 48'h0);
    wr_ctrl(8'h3C);
    chk(48'(ref_en), 48'h1);
    chk(48'(ctrl), 48'h80);
    hw <= 1'b1;
    $display("reference test done");
    // A second start edge while busy must be dropped
    start <= 3'b001;
    cyc(8);
    start <= 3'b011;
    wait_idle();
    start <= 3'h0;
    rd_word(val(0));
    rd_word(val(1));
    rd_word(val(1)); // Empty buffer repeats the last word
    $display("refused start test done");
    // Overfill the buffer: the sixth conversion stalls with busy high
    repeat (5) conv(3'b111, 1'b1);
    conv(3'b111, 1'b0);
    cyc(100);
    chk(48'(busy), 48'h1);
    for (int i = 0; i < 36; i++) rd_word(val(i % 6));
    chk(48'(busy), 48'h0);
    rd_word(val(5));
    $display("buffer fill test done");
    // Reset in mid-run
    wr_ctrl(8'h42);
    rst <= 1'b1;
    cyc(2);
    chk(48'({db_out, oe, ctrl, busy, ref_en, chain_en}), 48'h2);
    rst <= 1'b0;
    cyc(8);
    $display("reset test done");
    // Serial mode: read strobe low, unused upper bits grounded
    ser   <= 1'b1;
    rd_n  <= 1'b0;
    hi    <= 8'h00;
    sel   <= 3'b111;
    chain <= 1'b1;
    cyc(10);
    chk(48'(chain_en), 48'h1);
    chk(48'(oe), 48'h0);
    chain <= 1'b0;
    conv(3'b111, 1'b1);
    frame(3'b111, 16'h0700, {val(0), val(1), val(2)});
    frame(3'b001, 16'h0100, {val(3), 32'h0000_0000});
    frame(3'b011, 16'h0300, {val(4), val(5), 16'h0000});
    // Lane C without lane B takes the second word
    conv(3'b010, 1'b1);
    frame(3'b101, 16'h0500, {val(2), 16'h0000, val(3)});
    // Empty buffer shifts out zeros
    frame(3'b001, 16'h0100, 48'h0000_0000_0000);
    tally_and_finish();
  end
endmodule : ahi_pins_tb
